// file: include/cmsd_regs.vh
`ifndef CMSD_REGS_VH
`define CMSD_REGS_VH
// Register byte offsets
`define CMSD_ADDR_CMD 8'h00
`define CMSD_ADDR_OPND 8'h04
`define CMSD_ADDR_AF 8'h08
`define CMSD_ADDR_BC 8'h0C
`define CMSD_ADDR_DE 8'h10
`define CMSD_ADDR_HL 8'h14
`define CMSD_ADDR_SP 8'h18
`define CMSD_ADDR_PC 8'h1C
`define CMSD_ADDR_STAT 8'h20
// Command word fields
`define CMSD_CMD_OP 4:0
`define CMSD_CMD_SEL 10:8
`define CMSD_CMD_FN 14:12
`define CMSD_CMD_IMM 15
// Operation codes
`define CMSD_OP_SWAP 5'h00
`define CMSD_OP_SWAPALT 5'h01
`define CMSD_OP_PUSH 5'h02
`define CMSD_OP_POP 5'h03
`define CMSD_OP_CALL 5'h04
`define CMSD_OP_RET 5'h05
`define CMSD_OP_JPCC 5'h06
`define CMSD_OP_RETCC 5'h07
`define CMSD_OP_LOGIC 5'h08
`define CMSD_OP_SHIFT 5'h09
`define CMSD_OP_COPYREP 5'h0A
`define CMSD_OP_COPYSTEP 5'h0B
`define CMSD_OP_CMP 5'h0C
`define CMSD_OP_LOOP 5'h0D
`define CMSD_OP_ROT 5'h0E
`define CMSD_OP_DAA 5'h0F
`define CMSD_OP_SBC 5'h10
// Logic functions
`define CMSD_LG_AND 3'h0
`define CMSD_LG_OR 3'h1
`define CMSD_LG_XOR 3'h2
`define CMSD_LG_CPL 3'h3
`define CMSD_LG_NEG 3'h4
// Shift functions
`define CMSD_SH_RLC 3'h0
`define CMSD_SH_RRC 3'h1
`define CMSD_SH_RL 3'h2
`define CMSD_SH_RR 3'h3
`define CMSD_SH_SLA 3'h4
`define CMSD_SH_SRA 3'h5
`define CMSD_SH_SRL 3'h6
// Register select code for memory operand
`define CMSD_SEL_MEM 3'h6
// Flag bit positions
`define CMSD_F_S 7
`define CMSD_F_Z 6
`define CMSD_F_H 4
`define CMSD_F_P 2
`define CMSD_F_N 1
`define CMSD_F_C 0
// Bus responses
`define CMSD_RESP_OKAY 2'h0
`define CMSD_RESP_SLVERR 2'h2
// Cycles per byte of repeating copy
`define CMSD_COPY_CYCLES 5'h15
`endif

// file: logic/cmsd_core.v
`timescale 1ns/1ps
`default_nettype none
`include "cmsd_regs.vh"

// Overview of operation
// - Two swaps exchange whole main/alternate set
// - Push/pop pairs LIFO through stack pointer
// - Call pushes current program counter value
// - Return loads program counter from stack top
// - Stack pointer tracks top on push/pop/call/return
// - Six condition flags reflect operation results
// - Conditional jump/return test the chosen flag
// - AND/OR/XOR/complement/negate on accumulator
// - Shifts both ways on register or memory
// - Repeat copy moves bytes until counter zero
// - Repeat copy spends 21 cycles per byte
// - Step copy flags counter-zero on parity flag
// - Compare sets zero on equal, operands kept
// - Loop branch decrements counter, branches nonzero
// - Digit rotate accumulator low digit with memory
// - Decimal adjust makes accumulator packed BCD
// - Subtract memory byte from accumulator
module cmsd_core #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input wire ref_clk,
	input wire resetn,
	// AXI4-Lite write address
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// External memory
	output wire mem_req,
	output wire mem_we,
	output wire [15:0] mem_addr,
	output wire [7:0] mem_wdata,
	input wire [7:0] mem_rdata,
	// Status
	output wire busy
);

	////////////////////////////////////////////////////////////////////////////
	// Engine states
	localparam S_IDLE = 4'h0;
	localparam S_EXEC = 4'h1;
	localparam S_PUSH1 = 4'h2;
	localparam S_PUSH2 = 4'h3;
	localparam S_POP1 = 4'h4;
	localparam S_POP2 = 4'h5;
	localparam S_POP3 = 4'h6;
	localparam S_POP4 = 4'h7;
	localparam S_POP5 = 4'h8;
	localparam S_MRD = 4'h9;
	localparam S_MWT = 4'hA;
	localparam S_MEXE = 4'hB;
	localparam S_CWAIT = 4'hC;

	////////////////////////////////////////////////////////////////////////////
	// Helper functions
	// Subtract with borrow, returns {result, flags}
	function [15:0] cmsd_sub;
		input [7:0] x;
		input [7:0] y;
		input cin;
		reg [8:0] r;
		reg [4:0] h;
		begin
			r = {1'b0, x} - {1'b0, y} - {8'h00, cin};
			h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
			cmsd_sub = {r[7:0], r[7], (r[7:0] == 8'h00), 1'b0, h[4], 1'b0,
				(x[7] ^ y[7]) & (x[7] ^ r[7]), 1'b1, r[8]};
		end
	endfunction

	// Sign, zero and even-parity flags of a result
	function [7:0] cmsd_szp;
		input [7:0] r;
		input h;
		input n;
		input c;
		begin
			cmsd_szp = {r[7], (r == 8'h00), 1'b0, h, 1'b0, ~^r, n, c};
		end
	endfunction

	// Condition code test against flags
	function cmsd_cond;
		input [2:0] cc;
		input [7:0] f;
		begin
			case (cc)
				3'h0: cmsd_cond = ~f[`CMSD_F_Z];
				3'h1: cmsd_cond = f[`CMSD_F_Z];
				3'h2: cmsd_cond = ~f[`CMSD_F_C];
				3'h3: cmsd_cond = f[`CMSD_F_C];
				3'h4: cmsd_cond = ~f[`CMSD_F_P];
				3'h5: cmsd_cond = f[`CMSD_F_P];
				3'h6: cmsd_cond = ~f[`CMSD_F_S];
				default: cmsd_cond = f[`CMSD_F_S];
			endcase
		end
	endfunction

	// Byte-lane merge of a 16-bit register
	function [15:0] cmsd_merge;
		input [15:0] old;
		input [15:0] d;
		input [1:0] strb;
		begin
			cmsd_merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State
	reg [3:0] state_q; // Engine state
	reg [15:0] cmd_q; // Current command word
	reg [15:0] opnd_q; // Operand: immediate, target or offset
	reg [7:0] a_q, f_q, b_q, c_q, d_q, e_q, h_q, l_q; // Main set
	reg [15:0] alt_af_q, alt_bc_q, alt_de_q, alt_hl_q; // Alternate set
	reg [15:0] sp_q; // Stack pointer
	reg [15:0] pc_q; // Program counter
	reg [7:0] tmp_q; // Low byte from stack
	reg [4:0] cyc_q; // Cycle within copied byte
	reg mem_req_q, mem_we_q; // Memory strobes
	reg [15:0] mem_addr_q; // Memory address
	reg [7:0] mem_wdata_q; // Memory write data
	reg aw_full_q, w_full_q, bvalid_q; // Write channel holding
	reg [ADDR_W-1:0] aw_addr_q; // Held write address
	reg [15:0] w_data_q; // Held write data
	reg [1:0] w_strb_q; // Held byte enables
	reg [1:0] bresp_q; // Write response
	reg rvalid_q; // Read data valid
	reg [31:0] rdata_q; // Read data
	reg [1:0] rresp_q; // Read response

	// Command field views
	wire [4:0] op = cmd_q[`CMSD_CMD_OP];
	wire [2:0] sel = cmd_q[`CMSD_CMD_SEL];
	wire [2:0] fn = cmd_q[`CMSD_CMD_FN];
	wire [15:0] bc = {b_q, c_q};
	wire [15:0] de = {d_q, e_q};
	wire [15:0] hl = {h_q, l_q};
	wire [7:0] b_dec = b_q - 8'h01; // Loop counter after decrement

	////////////////////////////////////////////////////////////////////////////
	// Operand selection and stack data
	reg [7:0] reg_val; // Register picked by select code
	reg [15:0] pair_val; // Pair picked for push
	always @* begin
		case (sel)
			3'h0: reg_val = b_q;
			3'h1: reg_val = c_q;
			3'h2: reg_val = d_q;
			3'h3: reg_val = e_q;
			3'h4: reg_val = h_q;
			3'h5: reg_val = l_q;
			default: reg_val = a_q;
		endcase
		case (sel[1:0])
			2'h0: pair_val = bc;
			2'h1: pair_val = de;
			2'h2: pair_val = hl;
			default: pair_val = {a_q, f_q};
		endcase
		if (op == `CMSD_OP_CALL)
			pair_val = pc_q;
	end
	wire [7:0] ex_in = (state_q == S_MEXE) ? mem_rdata :
		(cmd_q[`CMSD_CMD_IMM] ? opnd_q[7:0] : reg_val);

	////////////////////////////////////////////////////////////////////////////
	// Execution unit: result, memory byte, flags
	reg [7:0] ex_res, ex_mem, ex_f, dcorr;
	reg sh_c;
	always @* begin
		ex_res = a_q;
		ex_mem = ex_in;
		ex_f = f_q;
		dcorr = 8'h00;
		sh_c = 1'b0;
		case (op)
			`CMSD_OP_LOGIC: begin
				case (fn)
					`CMSD_LG_AND: begin
						ex_res = a_q & ex_in;
						ex_f = cmsd_szp(ex_res, 1'b1, 1'b0, 1'b0);
					end
					`CMSD_LG_OR: begin
						ex_res = a_q | ex_in;
						ex_f = cmsd_szp(ex_res, 1'b0, 1'b0, 1'b0);
					end
					`CMSD_LG_XOR: begin
						ex_res = a_q ^ ex_in;
						ex_f = cmsd_szp(ex_res, 1'b0, 1'b0, 1'b0);
					end
					`CMSD_LG_CPL: begin
						ex_res = ~a_q;
						ex_f = {f_q[7:6], 1'b0, 1'b1, 1'b0, f_q[2], 1'b1, f_q[0]};
					end
					default: {ex_res, ex_f} = cmsd_sub(8'h00, a_q, 1'b0);
				endcase
			end
			`CMSD_OP_SHIFT: begin
				case (fn)
					`CMSD_SH_RLC: {sh_c, ex_res} = {ex_in[7], ex_in[6:0], ex_in[7]};
					`CMSD_SH_RRC: {sh_c, ex_res} = {ex_in[0], ex_in[0], ex_in[7:1]};
					`CMSD_SH_RL: {sh_c, ex_res} = {ex_in, f_q[`CMSD_F_C]};
					`CMSD_SH_RR: {sh_c, ex_res} = {ex_in[0], f_q[`CMSD_F_C], ex_in[7:1]};
					`CMSD_SH_SLA: {sh_c, ex_res} = {ex_in, 1'b0};
					`CMSD_SH_SRA: {sh_c, ex_res} = {ex_in[0], ex_in[7], ex_in[7:1]};
					default: {sh_c, ex_res} = {ex_in[0], 1'b0, ex_in[7:1]};
				endcase
				ex_mem = ex_res;
				ex_f = cmsd_szp(ex_res, 1'b0, 1'b0, sh_c);
			end
			`CMSD_OP_CMP: {ex_mem, ex_f} = cmsd_sub(a_q, ex_in, 1'b0);
			`CMSD_OP_SBC: {ex_res, ex_f} = cmsd_sub(a_q, ex_in, f_q[`CMSD_F_C]);
			`CMSD_OP_ROT: begin
				ex_res = {a_q[7:4], ex_in[7:4]};
				ex_mem = {ex_in[3:0], a_q[3:0]};
				ex_f = cmsd_szp(ex_res, 1'b0, 1'b0, f_q[`CMSD_F_C]);
			end
			`CMSD_OP_DAA: begin
				if (f_q[`CMSD_F_H] || (a_q[3:0] > 4'h9))
					dcorr[3:0] = 4'h6;
				if (f_q[`CMSD_F_C] || (a_q > 8'h99))
					dcorr[7:4] = 4'h6;
				ex_res = f_q[`CMSD_F_N] ? (a_q - dcorr) : (a_q + dcorr);
				ex_f = cmsd_szp(ex_res,
					f_q[`CMSD_F_N] ? (f_q[`CMSD_F_H] && (a_q[3:0] < 4'h6)) : (a_q[3:0] > 4'h9),
					f_q[`CMSD_F_N], f_q[`CMSD_F_C] || (a_q > 8'h99));
			end
			default: ;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Dispatch of a newly written command
	wire [4:0] w_op = w_data_q[`CMSD_CMD_OP];
	wire w_mem_src = (w_data_q[`CMSD_CMD_SEL] == `CMSD_SEL_MEM) && !w_data_q[`CMSD_CMD_IMM];
	reg [3:0] disp_state;
	always @* begin
		case (w_op)
			`CMSD_OP_PUSH, `CMSD_OP_CALL: disp_state = S_PUSH1;
			`CMSD_OP_POP, `CMSD_OP_RET: disp_state = S_POP1;
			`CMSD_OP_LOGIC, `CMSD_OP_SHIFT: disp_state = w_mem_src ? S_MRD : S_EXEC;
			`CMSD_OP_CMP, `CMSD_OP_SBC, `CMSD_OP_ROT: disp_state = S_MRD;
			`CMSD_OP_COPYREP, `CMSD_OP_COPYSTEP: disp_state = S_MRD;
			default: disp_state = S_EXEC;
		endcase
	end

	// Write address decode
	wire wr_hit = (aw_addr_q <= `CMSD_ADDR_STAT) && (aw_addr_q[1:0] == 2'h0);

	// Memory write request
	task mem_write;
		input [15:0] addr;
		input [7:0] data;
		begin
			mem_req_q <= 1'b1;
			mem_we_q <= 1'b1;
			mem_addr_q <= addr;
			mem_wdata_q <= data;
		end
	endtask

	// Memory read request
	task mem_read;
		input [15:0] addr;
		begin
			mem_req_q <= 1'b1;
			mem_addr_q <= addr;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Register writes and the instruction engine
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= S_IDLE;
			cmd_q <= 16'h0000;
			opnd_q <= 16'h0000;
			{a_q, f_q, b_q, c_q, d_q, e_q, h_q, l_q} <= 64'h0000000000000000;
			{alt_af_q, alt_bc_q, alt_de_q, alt_hl_q} <= 64'h0000000000000000;
			sp_q <= 16'hFFFF;
			pc_q <= 16'h0000;
			tmp_q <= 8'h00;
			cyc_q <= 5'h00;
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= 16'h0000;
			mem_wdata_q <= 8'h00;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			bvalid_q <= 1'b0;
			aw_addr_q <= {ADDR_W{1'b0}};
			w_data_q <= 16'h0000;
			w_strb_q <= 2'h0;
			bresp_q <= `CMSD_RESP_OKAY;
		end else begin
			// Strobes are single-cycle
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			// Hold address and data until both arrived
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata[15:0];
				w_strb_q <= s_axi_wstrb[1:0];
			end
			if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
			// Perform write; ignored while engine busy
			if (aw_full_q && w_full_q && !bvalid_q) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? `CMSD_RESP_OKAY : `CMSD_RESP_SLVERR;
				if (state_q == S_IDLE) begin
					case (aw_addr_q)
						`CMSD_ADDR_CMD: begin
							if (w_strb_q == 2'h3) begin
								cmd_q <= w_data_q;
								state_q <= disp_state;
							end
						end
						`CMSD_ADDR_OPND: opnd_q <= cmsd_merge(opnd_q, w_data_q, w_strb_q);
						`CMSD_ADDR_AF: {a_q, f_q} <= cmsd_merge({a_q, f_q}, w_data_q, w_strb_q);
						`CMSD_ADDR_BC: {b_q, c_q} <= cmsd_merge(bc, w_data_q, w_strb_q);
						`CMSD_ADDR_DE: {d_q, e_q} <= cmsd_merge(de, w_data_q, w_strb_q);
						`CMSD_ADDR_HL: {h_q, l_q} <= cmsd_merge(hl, w_data_q, w_strb_q);
						`CMSD_ADDR_SP: sp_q <= cmsd_merge(sp_q, w_data_q, w_strb_q);
						`CMSD_ADDR_PC: pc_q <= cmsd_merge(pc_q, w_data_q, w_strb_q);
						default: ;
					endcase
				end
			end
			case (state_q)
				S_IDLE: ; // Keeps a freshly dispatched command
				// Register-only operations
				S_EXEC: begin
					state_q <= S_IDLE;
					case (op)
						`CMSD_OP_SWAP: begin
							if (fn == 3'h0)
								{d_q, e_q, h_q, l_q} <= {hl, de};
							else
								{a_q, f_q, alt_af_q} <= {alt_af_q, a_q, f_q};
						end
						`CMSD_OP_SWAPALT: begin
							{b_q, c_q, d_q, e_q, h_q, l_q} <= {alt_bc_q, alt_de_q, alt_hl_q};
							{alt_bc_q, alt_de_q, alt_hl_q} <= {bc, de, hl};
						end
						`CMSD_OP_LOGIC, `CMSD_OP_DAA: begin
							a_q <= ex_res;
							f_q <= ex_f;
						end
						`CMSD_OP_SHIFT: begin
							f_q <= ex_f;
							case (sel)
								3'h0: b_q <= ex_res;
								3'h1: c_q <= ex_res;
								3'h2: d_q <= ex_res;
								3'h3: e_q <= ex_res;
								3'h4: h_q <= ex_res;
								3'h5: l_q <= ex_res;
								default: a_q <= ex_res;
							endcase
						end
						`CMSD_OP_JPCC: begin
							if (cmsd_cond(sel, f_q))
								pc_q <= opnd_q;
						end
						`CMSD_OP_RETCC: begin
							if (cmsd_cond(sel, f_q))
								state_q <= S_POP1;
						end
						`CMSD_OP_LOOP: begin
							b_q <= b_dec;
							if (b_dec != 8'h00)
								pc_q <= pc_q + {{8{opnd_q[7]}}, opnd_q[7:0]};
						end
						default: ;
					endcase
				end
				// Push high byte then low byte below the top
				S_PUSH1: begin
					mem_write(sp_q - 16'h0001, pair_val[15:8]);
					state_q <= S_PUSH2;
				end
				S_PUSH2: begin
					mem_write(sp_q - 16'h0002, pair_val[7:0]);
					sp_q <= sp_q - 16'h0002;
					if (op == `CMSD_OP_CALL)
						pc_q <= opnd_q;
					state_q <= S_IDLE;
				end
				// Pop low byte then high byte
				S_POP1: begin
					mem_read(sp_q);
					state_q <= S_POP2;
				end
				S_POP2: state_q <= S_POP3;
				S_POP3: begin
					tmp_q <= mem_rdata;
					mem_read(sp_q + 16'h0001);
					state_q <= S_POP4;
				end
				S_POP4: state_q <= S_POP5;
				S_POP5: begin
					sp_q <= sp_q + 16'h0002;
					state_q <= S_IDLE;
					if (op == `CMSD_OP_POP) begin
						case (sel[1:0])
							2'h0: {b_q, c_q} <= {mem_rdata, tmp_q};
							2'h1: {d_q, e_q} <= {mem_rdata, tmp_q};
							2'h2: {h_q, l_q} <= {mem_rdata, tmp_q};
							default: {a_q, f_q} <= {mem_rdata, tmp_q};
						endcase
					end else
						pc_q <= {mem_rdata, tmp_q};
				end
				// Read byte at source pointer
				S_MRD: begin
					mem_read(hl);
					cyc_q <= 5'h01;
					state_q <= S_MWT;
				end
				S_MWT: begin
					cyc_q <= cyc_q + 5'h01;
					state_q <= S_MEXE;
				end
				// Memory operand arrived
				S_MEXE: begin
					cyc_q <= cyc_q + 5'h01;
					state_q <= S_IDLE;
					case (op)
						`CMSD_OP_LOGIC, `CMSD_OP_SBC: begin
							a_q <= ex_res;
							f_q <= ex_f;
						end
						`CMSD_OP_CMP: f_q <= ex_f;
						`CMSD_OP_SHIFT: begin
							f_q <= ex_f;
							mem_write(hl, ex_mem);
						end
						`CMSD_OP_ROT: begin
							a_q <= ex_res;
							f_q <= ex_f;
							mem_write(hl, ex_mem);
						end
						default: begin
							mem_write(de, mem_rdata);
							{h_q, l_q} <= hl + 16'h0001;
							{d_q, e_q} <= de + 16'h0001;
							{b_q, c_q} <= bc - 16'h0001;
							f_q <= {f_q[7:6], 3'h0, (bc != 16'h0001), 1'b0, f_q[0]};
							if (op == `CMSD_OP_COPYREP)
								state_q <= S_CWAIT;
						end
					endcase
				end
				// Pad each copied byte to its full cycle count
				S_CWAIT: begin
					cyc_q <= cyc_q + 5'h01;
					if (cyc_q == `CMSD_COPY_CYCLES - 5'h01)
						state_q <= (bc != 16'h0000) ? S_MRD : S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read channel
	reg [31:0] rd_mux;
	reg rd_hit;
	always @* begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`CMSD_ADDR_CMD: rd_mux = {16'h0000, cmd_q};
			`CMSD_ADDR_OPND: rd_mux = {16'h0000, opnd_q};
			`CMSD_ADDR_AF: rd_mux = {16'h0000, a_q, f_q};
			`CMSD_ADDR_BC: rd_mux = {16'h0000, bc};
			`CMSD_ADDR_DE: rd_mux = {16'h0000, de};
			`CMSD_ADDR_HL: rd_mux = {16'h0000, hl};
			`CMSD_ADDR_SP: rd_mux = {16'h0000, sp_q};
			`CMSD_ADDR_PC: rd_mux = {16'h0000, pc_q};
			`CMSD_ADDR_STAT: rd_mux = {31'h00000000, state_q != S_IDLE};
			default: begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Capture read data, hold until taken
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `CMSD_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_hit ? `CMSD_RESP_OKAY : `CMSD_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// Outputs
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready = !w_full_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign mem_req = mem_req_q;
	assign mem_we = mem_we_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign busy = (state_q != S_IDLE);

endmodule // cmsd_core
`default_nettype wire

// file: test/cmsd_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cmsd_core_asserts (
	// Clock and reset
	input wire ref_clk,
	input wire resetn,
	// Register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Memory side
	input wire mem_req,
	input wire mem_we,
	input wire [15:0] mem_addr,
	input wire busy
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	wire rd_req = mem_req && !mem_we; // Memory read issued
	reg [4:0] gap_q; // Cycles since last read, saturating
	reg seen_q; // A read already seen in this busy run
	// Read spacing counter; seen flag cleared whenever the engine idles, gap count kept
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gap_q <= 5'h00;
			seen_q <= 1'b0;
		end else if (!busy) begin
			seen_q <= 1'b0;
		end else if (rd_req) begin
			gap_q <= 5'h01;
			seen_q <= 1'b1;
		end else if (gap_q != 5'h1F)
			gap_q <= gap_q + 5'h01;
	end
	////////////////////////////////////////
	AST_PUSH_ORDER: assert property ((mem_req && mem_we) ##1 (mem_req && mem_we) |->
		mem_addr == $past(mem_addr) - 16'h0001) else $error("stack writes not descending");
	AST_POP_ORDER: assert property (rd_req ##2 rd_req |->
		mem_addr == $past(mem_addr, 2) + 16'h0001) else $error("stack reads not ascending");
	AST_COPY_PACE: assert property (rd_req && seen_q |->
		gap_q == 5'd2 || gap_q == 5'd21) else $error("read spacing wrong");
	AST_MEM_IN_BUSY: assert property (mem_req |-> busy || $past(busy))
		else $error("memory access while idle");
	AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("second write answer");
	AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("second read answer");
endmodule // cmsd_core_asserts
bind cmsd_core cmsd_core_asserts i_cmsd_core_asserts (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.mem_req(mem_req),
	.mem_we(mem_we),
	.mem_addr(mem_addr),
	.busy(busy)
);
`default_nettype wire

// file: test/cmsd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmsd_mem_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Requests
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	// Read data
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535]; // Byte store
	logic [7:0] rd_q; // Last byte read
	logic vld_q; // Read data valid this cycle
	// Stale data shows inverted so a late capture is caught
	assign mem_rdata = vld_q ? rd_q : ~rd_q;
	// Answer one cycle after the request
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			vld_q <= 1'b0;
			rd_q <= 8'h00;
		end else begin
			vld_q <= mem_req && !mem_we;
			if (mem_req && mem_we)
				mem[mem_addr] <= mem_wdata;
			if (mem_req && !mem_we)
				rd_q <= mem[mem_addr];
		end
	end
endmodule // cmsd_mem_model
`default_nettype wire

// file: test/cmsd_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmsd_regs.vh"
module cmsd_core_tb;
	logic ref_clk, resetn, mreq, mwe, busy;
	// Register bus
	logic [7:0] awa, ara, mwd, mrd;
	logic [31:0] wd, rdat, rd;
	logic [3:0] ws;
	logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [1:0] bres, rres, rsp;
	// Memory side
	logic [15:0] madr;
	// Bookkeeping
	integer fail_count, cmp_count, i, cyc = 0, lrd = 0, gap = 0;
	logic [15:0] af, cm, ae, mk;
	logic [7:0] op, mi, me;
	// Rows: AF in, command, operand, (HL) in, AF want, AF mask, (HL) want
	logic [87:0] rows [0:11] = '{
		88'hF000_8008_3C_00_3014_FFFF_00, 88'h0000_1608_00_81_8184_FFFF_81,
		88'h5A00_2708_00_00_0044_FFFF_00, 88'h0F00_3008_00_00_F012_FFFF_00,
		88'h0100_4008_00_00_FF03_FF03_00, 88'h0000_4609_00_81_0001_FFFF_02,
		88'h0001_3609_00_02_0084_FFFF_81, 88'h1200_000E_00_34_1300_FF00_42,
		88'h0E12_000F_00_00_0800_FF01_00, 88'h2501_0010_00_17_0D00_FF01_17,
		88'h1000_0010_00_20_F001_FF01_20, 88'h2400_000C_00_24_2440_FF40_24};
	////////////////////////////////////////
	cmsd_core #(.ADDR_W(8)) i_cmsd_core (.ref_clk(ref_clk), .resetn(resetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bres), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.mem_req(mreq), .mem_we(mwe), .mem_addr(madr), .mem_wdata(mwd),
		.mem_rdata(mrd), .busy(busy));
	cmsd_mem_model i_cmsd_mem_model (.ref_clk(ref_clk), .resetn(resetn),
		.mem_req(mreq), .mem_we(mwe), .mem_addr(madr), .mem_wdata(mwd),
		.mem_rdata(mrd));
	////////////////////////////////////////
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Spacing of memory reads
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (mreq && !mwe) begin
			gap <= cyc - lrd;
			lrd <= cyc;
		end
	end
	task automatic test_done;
		$display("compares %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input [31:0] got, input [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: word %h want %h", $time, got, exp);
		end
	endtask
	task automatic chkm(input [7:0] got, input [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: byte %h want %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input integer k);
		if (k == 400) begin
			fail_count++;
			$display("unexpected at %0t: wait ran out", $time);
			test_done;
		end
	endtask
	// Bus write: address and data offered together
	task automatic axw(input [7:0] a, input [31:0] d);
		integer k;
		@(posedge ref_clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		k = 0;
		while (k < 400) begin
			@(posedge ref_clk);
			k++;
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
			if (bv && br) begin
				rsp = bres;
				br <= 1'b0;
				k = 999;
			end
		end
		tmo(k);
	endtask
	// Bus read
	task automatic axr(input [7:0] a);
		integer k;
		@(posedge ref_clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		k = 0;
		while (k < 400) begin
			@(posedge ref_clk);
			k++;
			if (arv && arr) arv <= 1'b0;
			if (rv && rr) begin
				rd = rdat;
				rsp = rres;
				rr <= 1'b0;
				k = 999;
			end
		end
		tmo(k);
	endtask
	// Issue a command, then poll busy
	task automatic run(input [15:0] c);
		integer k;
		axw(`CMSD_ADDR_CMD, {16'h0000, c});
		rd = 32'h1;
		k = 0;
		while (rd[0] !== 1'b0 && k < 400) begin
			axr(`CMSD_ADDR_STAT);
			k++;
		end
		tmo(k);
	endtask
	////////////////////////////////////////
	initial begin
		{fail_count, cmp_count} = 0;
		{awa, ara, wd, awv, wv, br, arv, rr} = 0;
		ws = 4'hF;
		resetn = 1'b0;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		axr(`CMSD_ADDR_SP);
		chk(rd, 32'h0000FFFF);
		axr(`CMSD_ADDR_PC);
		chk(rd, 32'h0);
		$display("test reset done");
		for (i = 0; i < 12; i++) begin
			{af, cm, op, mi, ae, mk, me} = rows[i];
			i_cmsd_mem_model.mem[16'h0100] = mi;
			axw(`CMSD_ADDR_AF, {16'h0, af});
			axw(`CMSD_ADDR_OPND, {24'h0, op});
			axw(`CMSD_ADDR_HL, 32'h0100);
			run(cm);
			axr(`CMSD_ADDR_AF);
			chk(rd & {16'h0, mk}, {16'h0, ae});
			chkm(i_cmsd_mem_model.mem[16'h0100], me);
		end
		$display("test table done");
		// Two pushes, two pops swapped
		axw(`CMSD_ADDR_BC, 32'h1234);
		axw(`CMSD_ADDR_DE, 32'h5678);
		run(16'h0002);
		run(16'h0102);
		axr(`CMSD_ADDR_SP);
		chk(rd, 32'hFFFB);
		chkm(i_cmsd_mem_model.mem[16'hFFFE], 8'h12);
		chkm(i_cmsd_mem_model.mem[16'hFFFB], 8'h78);
		run(16'h0203);
		run(16'h0103);
		axr(`CMSD_ADDR_HL);
		chk(rd, 32'h5678);
		axr(`CMSD_ADDR_DE);
		chk(rd, 32'h1234);
		// Call then return
		axw(`CMSD_ADDR_PC, 32'h0040);
		axw(`CMSD_ADDR_OPND, 32'h0200);
		run(16'h0004);
		chkm(i_cmsd_mem_model.mem[16'hFFFD], 8'h40);
		axr(`CMSD_ADDR_SP);
		chk(rd, 32'hFFFD);
		run(16'h0005);
		axr(`CMSD_ADDR_PC);
		chk(rd, 32'h0040);
		axr(`CMSD_ADDR_SP);
		chk(rd, 32'hFFFF);
		$display("test stack done");
		// Pair, alternate set and AF swaps
		run(16'h0000);
		axr(`CMSD_ADDR_DE);
		chk(rd, 32'h5678);
		run(16'h0001);
		axr(`CMSD_ADDR_BC);
		chk(rd, 32'h0);
		run(16'h1000);
		axr(`CMSD_ADDR_AF);
		chk(rd, 32'h0);
		run(16'h0001);
		axr(`CMSD_ADDR_BC);
		chk(rd, 32'h1234);
		$display("test swap done");
		// Each condition, flags clear then set
		for (i = 0; i < 16; i++) begin
			axw(`CMSD_ADDR_AF, (i < 8) ? 32'h0 : 32'h00C5);
			axw(`CMSD_ADDR_PC, 32'h0);
			axw(`CMSD_ADDR_OPND, 32'h0100 + i);
			run({5'h00, i[2:0], 8'h06});
			axr(`CMSD_ADDR_PC);
			chk(rd, (i[0] == i[3]) ? 32'h0100 + i : 32'h0);
		end
		$display("test branch done");
		// Step copy, last byte clears parity
		axw(`CMSD_ADDR_HL, 32'h0100);
		axw(`CMSD_ADDR_DE, 32'h0200);
		axw(`CMSD_ADDR_BC, 32'h0002);
		for (i = 0; i < 5; i++)
			i_cmsd_mem_model.mem[16'h0100 + i] = 8'hA0 + i[7:0];
		run(16'h000B);
		axr(`CMSD_ADDR_AF);
		chk(rd & 32'h4, 32'h4);
		run(16'h000B);
		axr(`CMSD_ADDR_AF);
		chk(rd & 32'h4, 32'h0);
		chkm(i_cmsd_mem_model.mem[16'h0201], 8'hA1);
		// Repeating copy of three bytes
		axw(`CMSD_ADDR_BC, 32'h0003);
		run(16'h000A);
		chkm(i_cmsd_mem_model.mem[16'h0204], 8'hA4);
		axr(`CMSD_ADDR_BC);
		chk(rd, 32'h0);
		axr(`CMSD_ADDR_HL);
		chk(rd, 32'h0105);
		chk(gap, 21);
		$display("test copy done");
		// Loop taken once, then falls through
		axw(`CMSD_ADDR_BC, 32'h0200);
		axw(`CMSD_ADDR_PC, 32'h0010);
		axw(`CMSD_ADDR_OPND, 32'h00FE);
		run(16'h000D);
		axr(`CMSD_ADDR_PC);
		chk(rd, 32'h000E);
		run(16'h000D);
		axr(`CMSD_ADDR_PC);
		chk(rd, 32'h000E);
		axr(`CMSD_ADDR_BC);
		chk(rd, 32'h0);
		$display("test loop done");
		// Unmapped place, then reset in mid run
		axr(8'h24);
		chk({30'h0, rsp}, {30'h0, `CMSD_RESP_SLVERR});
		axw(8'h24, 32'h1);
		chk({30'h0, rsp}, {30'h0, `CMSD_RESP_SLVERR});
		axw(`CMSD_ADDR_CMD, 32'h000A);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		axr(`CMSD_ADDR_SP);
		chk(rd, 32'h0000FFFF);
		$display("test error and reset done");
		test_done;
	end
endmodule // cmsd_core_tb
`default_nettype wire
